// >>> hw/fwc_pkg.sv
// Purpose: Shared constants and types of the flash write/reset/suspend controller
// Assumes: 25 MHz system clock
// Notes: Least times round up to whole cycles
package fwc_pkg;
  localparam int CLK_PER_NS = 40;
  localparam int CLK_MHZ = 25;
  // Pin timing in ns
  localparam int T_WP_NS = 50;
  localparam int T_WPH_NS = 30;
  localparam int T_RST_LO_NS = 100;
  localparam int T_RST_REC_NS = 150;
  localparam int T_RST_OUT_NS = 150;
  localparam int T_ACC_NS = 80;
  localparam int CYC_WP = (T_WP_NS + CLK_PER_NS - 1) / CLK_PER_NS;
  localparam int CYC_WPH = (T_WPH_NS + CLK_PER_NS - 1) / CLK_PER_NS;
  localparam int CYC_RST_LO = (T_RST_LO_NS + CLK_PER_NS - 1) / CLK_PER_NS;
  localparam int CYC_RST_WR = (T_RST_REC_NS + CLK_PER_NS - 1) / CLK_PER_NS;
  localparam int CYC_RST_RD = (T_RST_OUT_NS + CLK_PER_NS - 1) / CLK_PER_NS;
  localparam int CYC_RST_REC = (CYC_RST_WR > CYC_RST_RD) ? CYC_RST_WR : CYC_RST_RD;
  localparam int CYC_ACC = (T_ACC_NS + CLK_PER_NS - 1) / CLK_PER_NS;
  localparam int CYC_SYNC = 3;
  // Operation latencies
  localparam longint T_WPROG_US = 200;
  localparam longint T_BERASE_S = 5;
  localparam longint T_CHIP_S = 700;
  localparam longint T_SUSP_US = 20;
  localparam longint T_ERES_US = 500;
  localparam longint CYC_PER_US = CLK_MHZ;
  localparam longint CYC_PER_S = CYC_PER_US * 1000000;
  localparam int TW = 35;
  typedef logic [TW-1:0] fwc_tcnt_t;
  localparam fwc_tcnt_t CYC_SUSP = fwc_tcnt_t'(T_SUSP_US * CYC_PER_US);
  // Software register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_RDATA = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_IRQ_STAT = 8'h14;
  localparam logic [7:0] REG_IRQ_MASK = 8'h18;
  // Control register fields
  localparam int CTRL_GO = 0;
  localparam int CTRL_OP = 1;
  localparam int CTRL_SEL = 3;
  localparam int CTRL_KIND = 4;
  localparam int CTRL_TMO = 6;
  localparam int CTRL_VPP = 8;
  localparam int CTRL_W = 9;
  localparam logic [CTRL_W-1:0] CTRL_RST = 9'h000;
  // Status register fields
  localparam int ST_BUSY = 0;
  localparam int ST_VPP = 1;
  localparam int ST_GAP = 2;
  localparam int ST_SR = 8;
  // Interrupt bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ERR = 1;
  localparam int IRQ_TMO = 2;
  localparam int IRQ_W = 3;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;
  // Flash status byte
  localparam int SR_READY = 7;
  localparam logic [7:0] SR_ERR_MASK = 8'h3a;

  typedef enum logic [1:0] {
    OP_WRITE = 2'b00,
    OP_READ = 2'b01,
    OP_RESET = 2'b10,
    OP_POLL = 2'b11
  } fwc_op_t;

  typedef enum logic [1:0] {
    TMO_PROG = 2'b00,
    TMO_BERASE = 2'b01,
    TMO_CHIP = 2'b10,
    TMO_SUSP = 2'b11
  } fwc_tmo_t;

  localparam logic [1:0] KIND_SUSP = 2'h1;
  localparam logic [1:0] KIND_RES = 2'h2;

  typedef enum logic [3:0] {
    S_RST_LO = 4'b0000,
    S_RST_REC = 4'b0001,
    S_IDLE = 4'b0010,
    S_GAP_WAIT = 4'b0011,
    S_WR_SET = 4'b0100,
    S_WR_LO = 4'b0101,
    S_WR_HI = 4'b0110,
    S_RD_LO = 4'b0111,
    S_RD_SMP = 4'b1000,
    S_POLL_HI = 4'b1001
  } fwc_state_t;
endpackage

// >>> hw/fwc_sync.sv
// Purpose: Three-flop synchroniser for asynchronous pin inputs
// Assumes: Inputs change independently of clk
// Notes: stable is high while the last two stages agree
`timescale 1ns/1ps
module fwc_sync #(
  parameter int W = 16
) (
  input wire logic clk, // System clock
  input wire logic nrst, // Async reset, active low
  input wire logic [W-1:0] d, // Pin level
  output logic [W-1:0] q, // Synchronised level
  output logic stable // Last two stages agree
);
  typedef struct packed {
    logic [W-1:0] f1;
    logic [W-1:0] f2;
    logic [W-1:0] f3;
  } fwc_sync_t;

  fwc_sync_t s_r;
  fwc_sync_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.f1 = d;
    s_nxt.f2 = s_r.f1;
    s_nxt.f3 = s_r.f2;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign q = s_r.f3;
  assign stable = (s_r.f2 == s_r.f3);
endmodule

// >>> hw/fwc_timer.sv
// Purpose: Loadable down counter for operation timeouts and spacing
// Assumes: Loading zero stops the counter
// Notes: exp pulses in the same cycle the count reaches zero by itself
`timescale 1ns/1ps
module fwc_timer #(
  parameter int TW = 35
) (
  input wire logic clk, // System clock
  input wire logic nrst, // Async reset, active low
  input wire logic load, // Load pulse
  input wire logic [TW-1:0] val, // Count to load
  output logic run, // Counting
  output logic exp // Expiry pulse
);
  typedef struct packed {
    logic [TW-1:0] cnt;
    logic exp;
  } fwc_tmr_t;

  fwc_tmr_t s_r;
  fwc_tmr_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.exp = 1'b0;
    if (load) begin
      s_nxt.cnt = val;
    end else if (s_r.cnt != '0) begin
      s_nxt.cnt = s_r.cnt - TW'(1);
      s_nxt.exp = (s_r.cnt == TW'(1));
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign run = (s_r.cnt != '0);
  assign exp = s_r.exp;

  AST_TMR_LOAD: assert property (@(posedge clk) disable iff (!nrst)
    (load && val > TW'(1)) |=> run ##1 run) else $error("timer did not start"); // R19
  AST_TMR_EXP: assert property (@(posedge clk) disable iff (!nrst)
    exp |-> !run && $past(run, 2)) else $error("timer expiry without count"); // R19
endmodule

// >>> hw/fwc_ctrl.sv
// Purpose: Host controller driving an asynchronous parallel NOR flash
// Assumes: 25 MHz clk; flash pins are asynchronous to clk
// Notes: Software orders operations through CTRL and polls or takes irq
// Summary of operation
// R1 - Write cycle framed by chip select or strobe
// R2 - Combined low window at least 50 ns
// R3 - Hard reset held low at least 100 ns
// R4 - Device aborts running operation within 22 us
// R5 - Idle device finishes reset within 100 ns
// R6 - Output valid after reset-to-output delay
// R7 - Reset release to valid output 150 ns max
// R8 - Wait 150 ns after reset before writing
// R9 - Reset low 100 ns after power-up
// R10 - Query command clears ready bit promptly
// R11 - Status reads use ordinary read timing
// R12 - Keep programming supply until errors read zero
// R13 - Suspend ready within 10 or 20 us
// R14 - Ready bit rises after suspend latency
// R15 - Wait 500 us from resume to suspend
// R16 - Short resume intervals may starve erase
// R17 - Chip erase timeout at least 700 s
// R18 - Poll ready bit then check error bits
// R19 - Per-operation timeout counters flag errors
//
// Implementation choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module fwc_ctrl #(
  parameter int AW = 22,
  parameter int DW = 16,
  parameter fwc_pkg::fwc_tcnt_t TMO_PROG_CYC = fwc_pkg::fwc_tcnt_t'(fwc_pkg::T_WPROG_US * fwc_pkg::CYC_PER_US),
  parameter fwc_pkg::fwc_tcnt_t TMO_BERASE_CYC = fwc_pkg::fwc_tcnt_t'(fwc_pkg::T_BERASE_S * fwc_pkg::CYC_PER_S),
  parameter fwc_pkg::fwc_tcnt_t TMO_CHIP_CYC = fwc_pkg::fwc_tcnt_t'(fwc_pkg::T_CHIP_S * fwc_pkg::CYC_PER_S),
  parameter fwc_pkg::fwc_tcnt_t ERES_CYC = fwc_pkg::fwc_tcnt_t'(fwc_pkg::T_ERES_US * fwc_pkg::CYC_PER_US)
) (
  input wire logic clk, // System clock
  input wire logic nrst, // Async reset, active low
  input wire logic [7:0] sw_addr, // Register byte address
  input wire logic [31:0] sw_wdata, // Register write data
  input wire logic sw_wr, // Write strobe
  input wire logic sw_rd, // Read strobe
  output logic [31:0] sw_rdata, // Read data, cycle after sw_rd
  output logic irq, // Level interrupt
  output logic flash_ce_n, // Chip select
  output logic flash_we_n, // Write strobe
  output logic flash_oe_n, // Output strobe
  output logic flash_rst_n, // Hard reset
  output logic flash_vpp_en, // Programming supply enable
  output logic [AW-1:0] flash_addr, // Address
  output logic [DW-1:0] flash_dq_o, // Data out
  output logic flash_dq_oe_n, // Data drive, low while driving
  input wire logic [DW-1:0] flash_dq_i // Data in
);
  typedef struct packed {
    fwc_pkg::fwc_state_t st;
    logic [2:0] cnt;
    logic [fwc_pkg::CTRL_W-1:0] ctrl;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic [DW-1:0] rdata;
    logic [7:0] sr;
    logic [fwc_pkg::IRQ_W-1:0] irq_stat;
    logic [fwc_pkg::IRQ_W-1:0] irq_mask;
    logic irq;
    logic hold_vpp;
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic rst_n;
    logic vpp;
    logic dq_oe_n;
    logic [AW-1:0] a_o;
    logic [DW-1:0] dq_o;
    logic [31:0] sw_rdata;
  } fwc_ctrl_t;

  fwc_ctrl_t s_r;
  fwc_ctrl_t s_nxt;
  logic [DW-1:0] dq_q;
  logic dq_stable;
  logic tmo_load;
  fwc_pkg::fwc_tcnt_t tmo_val;
  logic tmo_run;
  logic tmo_exp;
  logic gap_load;
  logic gap_run;
  logic start;
  logic [fwc_pkg::IRQ_W-1:0] ev;
  logic [fwc_pkg::IRQ_W-1:0] clr;
  fwc_pkg::fwc_op_t op;
  fwc_pkg::fwc_tmo_t tsel;
  logic [1:0] kind;
  logic is_poll;

  fwc_sync #(.W(DW)) u_dq_sync (
    .clk(clk),
    .nrst(nrst),
    .d(flash_dq_i),
    .q(dq_q),
    .stable(dq_stable)
  );

  fwc_timer #(.TW(fwc_pkg::TW)) u_tmo (
    .clk(clk),
    .nrst(nrst),
    .load(tmo_load),
    .val(tmo_val),
    .run(tmo_run),
    .exp(tmo_exp)
  );

  fwc_timer #(.TW(fwc_pkg::TW)) u_gap (
    .clk(clk),
    .nrst(nrst),
    .load(gap_load),
    .val(ERES_CYC),
    .run(gap_run),
    .exp()
  );

  assign op = fwc_pkg::fwc_op_t'(s_r.ctrl[fwc_pkg::CTRL_OP +: 2]);
  assign tsel = fwc_pkg::fwc_tmo_t'(s_r.ctrl[fwc_pkg::CTRL_TMO +: 2]);
  assign kind = s_r.ctrl[fwc_pkg::CTRL_KIND +: 2];
  assign is_poll = (op == fwc_pkg::OP_POLL);

  always_comb begin
    s_nxt = s_r;
    start = 1'b0;
    ev = '0;
    clr = '0;
    tmo_load = 1'b0;
    tmo_val = '0;
    gap_load = 1'b0;
    s_nxt.sw_rdata = '0;
    if (s_r.cnt != 3'h0) begin
      s_nxt.cnt = s_r.cnt - 3'h1;
    end
    if (sw_rd) begin
      case (sw_addr)
        fwc_pkg::REG_CTRL: s_nxt.sw_rdata = 32'(s_r.ctrl);
        fwc_pkg::REG_ADDR: s_nxt.sw_rdata = 32'(s_r.addr);
        fwc_pkg::REG_WDATA: s_nxt.sw_rdata = 32'(s_r.wdata);
        fwc_pkg::REG_RDATA: s_nxt.sw_rdata = 32'(s_r.rdata);
        fwc_pkg::REG_STATUS: begin
          s_nxt.sw_rdata[fwc_pkg::ST_BUSY] = (s_r.st != fwc_pkg::S_IDLE);
          s_nxt.sw_rdata[fwc_pkg::ST_VPP] = s_r.vpp;
          s_nxt.sw_rdata[fwc_pkg::ST_GAP] = gap_run;
          s_nxt.sw_rdata[fwc_pkg::ST_SR +: 8] = s_r.sr;
        end
        fwc_pkg::REG_IRQ_STAT: s_nxt.sw_rdata = 32'(s_r.irq_stat);
        fwc_pkg::REG_IRQ_MASK: s_nxt.sw_rdata = 32'(s_r.irq_mask);
        default: s_nxt.sw_rdata = '0;
      endcase
    end
    // Orders and their operands are taken only while idle
    if (sw_wr) begin
      case (sw_addr)
        fwc_pkg::REG_CTRL: begin
          if (s_r.st == fwc_pkg::S_IDLE) begin
            s_nxt.ctrl = sw_wdata[fwc_pkg::CTRL_W-1:0];
            s_nxt.ctrl[fwc_pkg::CTRL_GO] = 1'b0;
            start = sw_wdata[fwc_pkg::CTRL_GO];
          end
        end
        fwc_pkg::REG_ADDR: begin
          if (s_r.st == fwc_pkg::S_IDLE) begin
            s_nxt.addr = sw_wdata[AW-1:0];
          end
        end
        fwc_pkg::REG_WDATA: begin
          if (s_r.st == fwc_pkg::S_IDLE) begin
            s_nxt.wdata = sw_wdata[DW-1:0];
          end
        end
        fwc_pkg::REG_IRQ_STAT: clr = sw_wdata[fwc_pkg::IRQ_W-1:0];
        fwc_pkg::REG_IRQ_MASK: s_nxt.irq_mask = sw_wdata[fwc_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end
    unique case (s_r.st)
      fwc_pkg::S_RST_LO: begin
        if (s_r.cnt == 3'h0) begin
          s_nxt.rst_n = 1'b1;
          s_nxt.cnt = 3'(fwc_pkg::CYC_RST_REC - 1); // R8 R7
          s_nxt.st = fwc_pkg::S_RST_REC;
        end
      end
      fwc_pkg::S_RST_REC: begin
        if (s_r.cnt == 3'h0) begin
          ev[fwc_pkg::IRQ_DONE] = 1'b1;
          s_nxt.st = fwc_pkg::S_IDLE;
        end
      end
      fwc_pkg::S_IDLE: begin
        if (start) begin
          unique case (fwc_pkg::fwc_op_t'(s_nxt.ctrl[fwc_pkg::CTRL_OP +: 2]))
            fwc_pkg::OP_WRITE: begin
              if (s_nxt.ctrl[fwc_pkg::CTRL_KIND +: 2] == fwc_pkg::KIND_SUSP && gap_run) begin
                s_nxt.st = fwc_pkg::S_GAP_WAIT; // R15 R16
              end else begin
                s_nxt.st = fwc_pkg::S_WR_SET;
              end
            end
            fwc_pkg::OP_READ: s_nxt.st = fwc_pkg::S_RD_LO;
            fwc_pkg::OP_RESET: begin
              s_nxt.rst_n = 1'b0;
              s_nxt.cnt = 3'(fwc_pkg::CYC_RST_LO - 1); // R3
              s_nxt.st = fwc_pkg::S_RST_LO;
            end
            fwc_pkg::OP_POLL: begin
              tmo_load = 1'b1; // R19
              unique case (fwc_pkg::fwc_tmo_t'(s_nxt.ctrl[fwc_pkg::CTRL_TMO +: 2]))
                fwc_pkg::TMO_PROG: tmo_val = TMO_PROG_CYC;
                fwc_pkg::TMO_BERASE: tmo_val = TMO_BERASE_CYC;
                fwc_pkg::TMO_CHIP: tmo_val = TMO_CHIP_CYC; // R17
                fwc_pkg::TMO_SUSP: tmo_val = fwc_pkg::CYC_SUSP; // R13 R14
              endcase
              s_nxt.st = fwc_pkg::S_RD_LO;
            end
          endcase
          if (s_nxt.st == fwc_pkg::S_RD_LO) begin
            s_nxt.a_o = s_nxt.addr;
            s_nxt.ce_n = 1'b0;
            s_nxt.oe_n = 1'b0; // R11
            s_nxt.cnt = 3'(fwc_pkg::CYC_ACC - 1);
          end
        end
      end
      fwc_pkg::S_GAP_WAIT: begin
        if (!gap_run) begin
          s_nxt.st = fwc_pkg::S_WR_SET; // R15
        end
      end
      fwc_pkg::S_WR_SET: begin
        // The non-selected strobe falls first, the selected one frames the pulse
        s_nxt.a_o = s_r.addr;
        s_nxt.dq_o = s_r.wdata;
        s_nxt.dq_oe_n = 1'b0;
        s_nxt.ce_n = !s_r.ctrl[fwc_pkg::CTRL_SEL] ? 1'b0 : 1'b1; // R1
        s_nxt.we_n = s_r.ctrl[fwc_pkg::CTRL_SEL] ? 1'b0 : 1'b1; // R1
        if (s_r.ctrl[fwc_pkg::CTRL_VPP]) begin
          s_nxt.hold_vpp = 1'b1; // R12
        end
        if ((s_r.ctrl[fwc_pkg::CTRL_SEL] ? s_r.we_n : s_r.ce_n) == 1'b0) begin
          s_nxt.ce_n = 1'b0;
          s_nxt.we_n = 1'b0;
          s_nxt.cnt = 3'(fwc_pkg::CYC_WP - 1); // R2
          s_nxt.st = fwc_pkg::S_WR_LO;
        end
      end
      fwc_pkg::S_WR_LO: begin
        if (s_r.cnt == 3'h0) begin
          s_nxt.ce_n = 1'b1;
          s_nxt.we_n = 1'b1;
          s_nxt.cnt = 3'(fwc_pkg::CYC_WPH - 1);
          s_nxt.st = fwc_pkg::S_WR_HI;
        end
      end
      fwc_pkg::S_WR_HI: begin
        if (s_r.cnt == 3'h0) begin
          gap_load = (kind == fwc_pkg::KIND_RES); // R15
          s_nxt.dq_oe_n = 1'b1; // Data held one cycle past the strobe rise
          ev[fwc_pkg::IRQ_DONE] = 1'b1;
          s_nxt.st = fwc_pkg::S_IDLE;
        end
      end
      fwc_pkg::S_RD_LO: begin
        if (s_r.cnt == 3'h0) begin
          s_nxt.cnt = 3'(fwc_pkg::CYC_SYNC - 1);
          s_nxt.st = fwc_pkg::S_RD_SMP;
        end
      end
      fwc_pkg::S_RD_SMP: begin
        if (s_r.cnt == 3'h0 && dq_stable) begin
          s_nxt.rdata = dq_q;
          s_nxt.ce_n = 1'b1;
          s_nxt.oe_n = 1'b1;
          s_nxt.st = fwc_pkg::S_IDLE;
          if (!is_poll) begin
            ev[fwc_pkg::IRQ_DONE] = 1'b1;
          end else if (dq_q[fwc_pkg::SR_READY]) begin
            s_nxt.sr = dq_q[7:0]; // R18
            ev[fwc_pkg::IRQ_DONE] = 1'b1;
            tmo_load = 1'b1;
            if ((dq_q[7:0] & fwc_pkg::SR_ERR_MASK) != 8'h00) begin
              ev[fwc_pkg::IRQ_ERR] = 1'b1; // R18
            end else begin
              s_nxt.hold_vpp = 1'b0; // R12
            end
          end else begin
            s_nxt.sr = dq_q[7:0];
            s_nxt.cnt = 3'(fwc_pkg::CYC_WPH - 1);
            s_nxt.st = fwc_pkg::S_POLL_HI;
          end
        end
      end
      fwc_pkg::S_POLL_HI: begin
        if (s_r.cnt == 3'h0) begin
          s_nxt.ce_n = 1'b0;
          s_nxt.oe_n = 1'b0;
          s_nxt.cnt = 3'(fwc_pkg::CYC_ACC - 1);
          s_nxt.st = fwc_pkg::S_RD_LO;
        end
      end
      default: s_nxt.st = fwc_pkg::S_IDLE;
    endcase
    // Timeout ends a poll wherever it stands
    if (is_poll && tmo_exp && s_r.st inside {fwc_pkg::S_RD_LO, fwc_pkg::S_RD_SMP, fwc_pkg::S_POLL_HI}) begin
      s_nxt.ce_n = 1'b1;
      s_nxt.oe_n = 1'b1;
      s_nxt.st = fwc_pkg::S_IDLE;
      ev = '0;
      ev[fwc_pkg::IRQ_TMO] = 1'b1; // R19
    end
    s_nxt.vpp = s_nxt.ctrl[fwc_pkg::CTRL_VPP] | s_nxt.hold_vpp; // R12
    s_nxt.irq_stat = (s_r.irq_stat & ~clr) | ev;
    s_nxt.irq = |(s_nxt.irq_stat & s_nxt.irq_mask);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_r <= '0;
      s_r.st <= fwc_pkg::S_RST_LO; // R9
      s_r.cnt <= 3'(fwc_pkg::CYC_RST_LO - 1);
      s_r.ctrl <= fwc_pkg::CTRL_RST;
      s_r.irq_mask <= fwc_pkg::IRQ_MASK_RST;
      s_r.ce_n <= 1'b1;
      s_r.we_n <= 1'b1;
      s_r.oe_n <= 1'b1;
      s_r.dq_oe_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sw_rdata = s_r.sw_rdata;
  assign irq = s_r.irq;
  assign flash_ce_n = s_r.ce_n;
  assign flash_we_n = s_r.we_n;
  assign flash_oe_n = s_r.oe_n;
  assign flash_rst_n = s_r.rst_n;
  assign flash_vpp_en = s_r.vpp;
  assign flash_addr = s_r.a_o;
  assign flash_dq_o = s_r.dq_o;
  assign flash_dq_oe_n = s_r.dq_oe_n;

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  AST_WR_PULSE: assert property ($fell(flash_ce_n | flash_we_n) |-> !(flash_ce_n | flash_we_n) [*2]) // R2
    else $error("write pulse shorter than 50 ns");
  AST_WR_FRAME: assert property ($fell(flash_ce_n | flash_we_n) |-> flash_oe_n && !flash_dq_oe_n && $past(flash_ce_n != flash_we_n)) // R1
    else $error("write pulse not framed by one strobe");
  AST_RST_HOLD: assert property ($fell(flash_rst_n) |-> !flash_rst_n [*3]) // R3
    else $error("hard reset shorter than 100 ns");
  AST_RST_WR: assert property ($rose(flash_rst_n) |-> (flash_ce_n | flash_we_n) [*4]) // R8
    else $error("write too soon after reset");
  AST_RST_RD: assert property ($rose(flash_rst_n) |-> (flash_ce_n | flash_oe_n) [*4]) // R6
    else $error("read before reset-to-output delay");
  AST_VPP_HOLD: assert property (s_r.hold_vpp |-> flash_vpp_en) // R12
    else $error("programming supply dropped before success");
  AST_GAP: assert property (($past(s_r.st) == fwc_pkg::S_WR_SET) && s_r.st == fwc_pkg::S_WR_LO
    && kind == fwc_pkg::KIND_SUSP |-> !gap_run) // R15
    else $error("suspend inside resume interval");
  AST_POLL_ERR: assert property ($rose(s_r.irq_stat[fwc_pkg::IRQ_ERR]) |-> s_r.sr[fwc_pkg::SR_READY]
    && (s_r.sr & fwc_pkg::SR_ERR_MASK) != 8'h00) // R18
    else $error("error flagged without ready status");
  AST_TMO: assert property ($rose(s_r.irq_stat[fwc_pkg::IRQ_TMO]) |-> $past(tmo_exp) && s_r.st == fwc_pkg::S_IDLE) // R19
    else $error("timeout flagged without expiry");
endmodule

// >>> sim/fwc_flash_model.sv
// Purpose: Behavioural flash device facing the controller pins
// Assumes: Command words and latencies are this model's own, in ns
// Notes: viol counts host timing breaches; err_inj and slow inject faults
`timescale 1ns/1ps
module fwc_flash_model #(
  parameter int PROG_NS = 400,
  parameter int SLOW_NS = 4000,
  parameter int SUSP_NS = 2000,
  parameter int ERES_NS = 1200
) (
  input wire logic ce_n, // Chip select
  input wire logic we_n, // Write strobe
  input wire logic oe_n, // Output strobe
  input wire logic rst_n, // Hard reset
  input wire logic vpp_en, // Programming supply
  input wire logic [21:0] addr, // Address
  input wire logic [15:0] dq_w, // Data bus level
  output logic [15:0] dq_r, // Data driven by the device
  input wire logic err_inj, // Fail the next program
  input wire logic slow, // Stretch the next program
  output logic [15:0] last_cmd, // Last accepted word
  output int viol // Host breaches seen
);
  logic [7:0] sr = 8'h80;
  logic st_mode = 1'b0;
  logic out_ok = 1'b0;
  logic need_vpp = 1'b0;
  realtime t_fall = 0;
  realtime t_rlo = 0;
  realtime t_rst = 0;
  realtime t_res = -1.0e9;
  int gen = 0;
  wire wr_lo = !ce_n && !we_n;
  wire sel = !ce_n && !oe_n && (rst_n === 1'b1) && out_ok;

  initial begin
    viol = 0;
    dq_r = 16'h0;
    last_cmd = 16'h0;
  end

  // A newer operation or a reset cancels the pending one
  task automatic run(input int d, input logic [7:0] e);
    int g;
    gen++;
    g = gen;
    sr[7] = 1'b0;
    #(d);
    if (g == gen) sr = sr | 8'h80 | e;
  endtask

  always @(negedge rst_n) begin
    gen++;
    sr = 8'h80;
    st_mode = 1'b0;
    need_vpp = 1'b0;
    out_ok = 1'b0;
    t_rlo = $realtime;
  end

  always @(posedge rst_n) begin
    if ($realtime - t_rlo < 100) viol++;
    t_rst = $realtime;
    out_ok <= #150 1'b1;
  end

  always @(posedge wr_lo) t_fall = $realtime;

  always @(negedge wr_lo) if (rst_n === 1'b1) begin
    if ($realtime - t_fall < 50) viol++;
    if (t_fall - t_rst < 150) viol++;
    last_cmd = dq_w;
    st_mode = 1'b1;
    case (dq_w)
      16'h0040: begin
        need_vpp = 1'b1;
        fork run(slow ? SLOW_NS : PROG_NS, err_inj ? 8'h10 : 8'h00); join_none
      end
      16'h0020, 16'h0030: begin
        need_vpp = 1'b1;
        fork run(100000, 8'h00); join_none
      end
      16'h00b0: begin
        if ($realtime - t_res < ERES_NS) viol++;
        fork run(SUSP_NS, 8'h40); join_none
      end
      16'h00d0: begin
        // Erase restarts in full, so short resume gaps starve it
        t_res = $realtime;
        sr[6] = 1'b0;
        fork run(100000, 8'h00); join_none
      end
      16'h0098, 16'h0090: sr[7] = 1'b0;
      16'h0050: sr = sr & 8'hc5;
      default: st_mode = (dq_w == 16'h0070);
    endcase
  end

  // Deselected bus shows a changing pattern, never the last value
  always @(sel, sr, st_mode, addr) begin
    if (sel) begin
      dq_r <= #60 st_mode ? {8'h00, sr} : addr[15:0] ^ 16'h5a5a;
      if (st_mode && sr[7] && (sr & 8'h3a) == 8'h00) need_vpp <= #60 1'b0;
    end else begin
      dq_r = ~dq_r;
    end
  end

  always @(negedge vpp_en) if (need_vpp) viol++;
endmodule

// >>> sim/fwc_ctrl_tb_top.sv
// Purpose: Self-checking bench for the flash controller
// Assumes: Shortened timeouts, flash model command words
// Notes: All orders go through the software register port
`timescale 1ns/1ps
module fwc_ctrl_tb_top;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] sw_addr = 8'h00;
  logic [31:0] sw_wdata = 32'h0;
  logic sw_wr = 1'b0;
  logic sw_rd = 1'b0;
  logic err_inj = 1'b0;
  logic slow = 1'b0;
  logic [31:0] sw_rdata;
  logic irq, ce_n, we_n, oe_n, rst_n, vpp_en, dq_oe_n;
  logic [21:0] fa;
  logic [15:0] dq_o, dq_i, dq_r, last_cmd;
  int viol;
  int miscompares = 0;
  int comparisons = 0;
  logic [31:0] d;
  assign dq_i = dq_oe_n ? dq_r : dq_o;

  fwc_ctrl #(.TMO_PROG_CYC(35'd40), .TMO_BERASE_CYC(35'd60), .TMO_CHIP_CYC(35'd80), .ERES_CYC(35'd30)) DUT (
    .clk(clk), .nrst(nrst), .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
    .sw_rdata(sw_rdata), .irq(irq), .flash_ce_n(ce_n), .flash_we_n(we_n), .flash_oe_n(oe_n),
    .flash_rst_n(rst_n), .flash_vpp_en(vpp_en), .flash_addr(fa), .flash_dq_o(dq_o),
    .flash_dq_oe_n(dq_oe_n), .flash_dq_i(dq_i));

  fwc_flash_model fm (.ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .rst_n(rst_n), .vpp_en(vpp_en),
    .addr(fa), .dq_w(dq_i), .dq_r(dq_r), .err_inj(err_inj), .slow(slow), .last_cmd(last_cmd), .viol(viol));

  initial begin
    forever #20 clk = ~clk;
  end

  task automatic test_done();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    sw_addr <= a;
    sw_wdata <= v;
    sw_wr <= 1'b1;
    @(posedge clk);
    sw_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clk);
    sw_rd <= 1'b0;
    @(negedge clk);
    v = sw_rdata;
  endtask

  function automatic logic [8:0] cw(input logic [1:0] o, input logic s, input logic [1:0] k,
                                    input logic [1:0] t, input logic v);
    return {v, t, k, s, o, 1'b1};
  endfunction

  task automatic idle();
    logic [31:0] v;
    int n;
    v = 32'h1;
    n = 0;
    while (v[0] !== 1'b0 && n < 3000) begin
      rd(fwc_pkg::REG_STATUS, v);
      n++;
    end
    chk("busy", {31'h0, v[0]}, 32'h0);
  endtask

  task automatic op(input logic [8:0] c);
    wr(fwc_pkg::REG_CTRL, {23'h0, c});
    idle();
  endtask

  task automatic fw(input logic [15:0] c, input logic s, input logic [1:0] k);
    wr(fwc_pkg::REG_WDATA, {16'h0, c});
    op(cw(2'h0, s, k, 2'h0, 1'b1));
    chk("command", {16'h0, last_cmd}, {16'h0, c});
  endtask

  task automatic poll(input logic [1:0] t, input logic [31:0] m, input logic [31:0] es, input logic [2:0] ei);
    logic [31:0] v;
    wr(fwc_pkg::REG_IRQ_STAT, 32'h7);
    op(cw(2'h3, 1'b0, 2'h0, t, 1'b0));
    rd(fwc_pkg::REG_STATUS, v);
    chk("status", v & m, es);
    chk("irq", {31'h0, irq}, 32'h1);
    rd(fwc_pkg::REG_IRQ_STAT, v);
    chk("irq_stat", v, {29'h0, ei});
  endtask

  initial begin
    #1000000;
    miscompares++;
    test_done();
  end

  initial begin
    repeat (4) @(posedge clk);
    chk("rst_n", {31'h0, rst_n}, 32'h0);
    nrst <= 1'b1;
    idle();
    rd(fwc_pkg::REG_IRQ_STAT, d);
    chk("irq_stat", d, 32'h1);
    rd(fwc_pkg::REG_IRQ_MASK, d);
    chk("irq_mask", d, 32'h0);
    wr(8'h1c, 32'hffffffff);
    rd(8'h1c, d);
    chk("unmapped", d, 32'h0);
    for (int s = 0; s < 2; s++) fw(16'h00fe + 16'(s), s[0], 2'h0);
    chk("irq", {31'h0, irq}, 32'h0);
    wr(fwc_pkg::REG_ADDR, 32'h00012345);
    op(cw(2'h1, 1'b0, 2'h0, 2'h0, 1'b0));
    rd(fwc_pkg::REG_RDATA, d);
    chk("rdata", d, 32'h0000791f);
    wr(fwc_pkg::REG_IRQ_MASK, 32'h7);
    fw(16'h0040, 1'b0, 2'h0);
    poll(2'h0, 32'hffff, 32'h8000, 3'h1);
    err_inj <= 1'b1;
    fw(16'h0040, 1'b1, 2'h0);
    err_inj <= 1'b0;
    poll(2'h0, 32'hffff, 32'h9002, 3'h3);
    fw(16'h0050, 1'b0, 2'h0);
    poll(2'h0, 32'hffff, 32'h8000, 3'h1);
    slow <= 1'b1;
    fw(16'h0040, 1'b0, 2'h0);
    poll(2'h0, 32'h3, 32'h2, 3'h4);
    slow <= 1'b0;
    op(cw(2'h2, 1'b0, 2'h0, 2'h0, 1'b0));
    fw(16'h0070, 1'b0, 2'h0);
    poll(2'h1, 32'hffff, 32'h8000, 3'h1);
    fw(16'h0020, 1'b0, 2'h0);
    fw(16'h00b0, 1'b0, 2'h1);
    poll(2'h3, 32'hffff, 32'hc000, 3'h1);
    fw(16'h00d0, 1'b0, 2'h2);
    wr(fwc_pkg::REG_WDATA, 32'h00b0);
    wr(fwc_pkg::REG_CTRL, {23'h0, cw(2'h0, 1'b0, 2'h1, 2'h0, 1'b1)});
    rd(fwc_pkg::REG_STATUS, d);
    chk("gap", {30'h0, d[2], d[0]}, 32'h3);
    idle();
    chk("command", {16'h0, last_cmd}, 32'h00b0);
    poll(2'h3, 32'hffff, 32'hc000, 3'h1);
    fw(16'h0098, 1'b0, 2'h0);
    poll(2'h0, 32'h3, 32'h2, 3'h4);
    op(cw(2'h2, 1'b0, 2'h0, 2'h0, 1'b0));
    fw(16'h0070, 1'b0, 2'h0);
    poll(2'h2, 32'hffff, 32'h8000, 3'h1);
    chk("violations", 32'(viol), 32'h0);
    test_done();
  end
endmodule
